// *** xps_i2c_master.sv ***
// Behavioural serial bus master that drives the crosspoint control block.
`timescale 1ns/1ps
`default_nettype none
module xps_i2c_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // ---------------------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------------------
  // Both lines start released; the pull-ups hold them high while the bus idles.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // One quarter of the 160 ns bus period, counted on falling clock edges.
  task automatic quarter();
    repeat (4) @(negedge i_clk);
  endtask : quarter

  // Data falls while the clock is high to open a frame.
  task automatic start();
    quarter();
    o_sda_low = 1'b0;
    quarter();
    o_scl = 1'b1;
    quarter();
    o_sda_low = 1'b1;
    quarter();
    o_scl = 1'b0;
  endtask : start

  // Data moves only in the clock low phase and is sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    quarter();
    o_sda_low = !b;
    quarter();
    o_scl = 1'b1;
    quarter();
    r = i_sda;
    quarter();
    o_scl = 1'b0;
  endtask : bit_io

  // Eight bits most significant first, then the receiver's acknowledge slot.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : wbyte

  // Reads one byte; the last one is answered with a no-acknowledge.
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask : rbyte

  // Data is pulled low in the low phase, then rises while the clock is high.
  task automatic stop();
    quarter();
    o_sda_low = 1'b1;
    quarter();
    o_scl = 1'b1;
    quarter();
    o_sda_low = 1'b0;
    quarter();
  endtask : stop
endmodule : xps_i2c_master
`default_nettype wire

// *** xps_pkg.sv ***
// Shared constants and types for the crosspoint switch control block.
package xps_pkg;

  // ---------------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------------
  localparam int ROWS = 10;
  localparam int COLS = 8;
  localparam int SWITCHES = 80;

  // ---------------------------------------------------------------------------
  // Slave address and serial framing
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_FIXED = 4'he;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ROW_IDX_LAST = 4'h9;

  // ---------------------------------------------------------------------------
  // Field positions inside the 16-bit command word
  // ---------------------------------------------------------------------------
  localparam int WORD_DATA_POS = 15;
  localparam int WORD_ROW_MSB = 14;
  localparam int WORD_ROW_LSB = 11;
  localparam int WORD_COL_MSB = 10;
  localparam int WORD_COL_LSB = 8;
  localparam int WORD_LOAD_POS = 0;

  // ---------------------------------------------------------------------------
  // Row code ranges
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ROW_LOW_FIRST = 4'h2;
  localparam logic [3:0] ROW_LOW_LAST = 4'h5;
  localparam logic [3:0] ROW_HIGH_FIRST = 4'h8;
  localparam logic [3:0] ROW_HIGH_LAST = 4'hd;
  localparam logic [3:0] ROW_HIGH_BASE_IDX = 4'h4;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [5:0] SYNC_RESET = 6'h3f;
  localparam logic [79:0] SWITCH_RESET = 80'h0;

  // ---------------------------------------------------------------------------
  // Serial engine states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    XPS_IDLE,
    XPS_ADDR,
    XPS_ACK,
    XPS_WRITE,
    XPS_READ,
    XPS_RD_ACK,
    XPS_RD_NEXT,
    XPS_IGNORE
  } xps_state_t;

endpackage : xps_pkg

// *** xps_row_decode.sv ***
// Row select field decoder with reserved code detection.
`timescale 1ns/1ps
`default_nettype none
module xps_row_decode (
  input wire logic [3:0] i_code,
  output wire logic [9:0] o_row_hot,
  output logic o_valid
);

  logic [3:0] idx;

  // ---------------------------------------------------------------------------
  // Code to index
  // ---------------------------------------------------------------------------
  // Two code ranges map onto rows; every other code is reserved.
  always_comb begin
    idx = 4'h0;
    o_valid = 1'b0;
    if (i_code >= xps_pkg::ROW_LOW_FIRST && i_code <= xps_pkg::ROW_LOW_LAST) begin
      idx = i_code - xps_pkg::ROW_LOW_FIRST;
      o_valid = 1'b1;
    end else if (i_code >= xps_pkg::ROW_HIGH_FIRST && i_code <= xps_pkg::ROW_HIGH_LAST) begin
      idx = i_code - xps_pkg::ROW_HIGH_FIRST + xps_pkg::ROW_HIGH_BASE_IDX;
      o_valid = 1'b1;
    end
  end

  // One-hot row lines, all low for reserved codes.
  for (genvar r = 0; r < xps_pkg::ROWS; r++) begin : g_row
    assign o_row_hot[r] = o_valid && (idx == 4'(r));
  end

endmodule : xps_row_decode
`default_nettype wire

// *** xps_switch_ctrl.sv ***
// Serial slave and switch state registers for an 8 by 10 crosspoint array.
//
// Functional notes
// - Reset pin low opens all 80 switches.
// - Power-up clears every register to zero; the line samples and synchroniser reset high.
// - Load bit set applies word immediately.
// - Load bit clear latches; later load applies all.
// - Master can read back switch states.
// - Slave only; never drives the clock.
// - Standard and fast rates; high speed optional.
// - Address is 1110 plus three select pins.
// - Falling data while clock high starts.
// - Eight bits in: address MSB first, direction.
// - Matching address acknowledged on ninth pulse.
// - Direction one reads, zero writes.
// - Bytes are nine pulses including acknowledge.
// - Data changes only while clock is low.
// - Rising data while clock high stops.
// - Ten rows, eight columns, any combination.
// - Write word is address plus two bytes.
// - Data, row, column, load bit field layout.
// - Row codes decode; others are reserved.
`timescale 1ns/1ps
`default_nettype none
module xps_switch_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_reset_pin_n,
  input wire logic i_addr_select_pin_0,
  input wire logic i_addr_select_pin_1,
  input wire logic i_addr_select_pin_2,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [79:0] o_switch_closed,
  output logic [79:0] o_switch_pending
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [5:0] pins_s;
  logic scl_s, sda_s, rpin_s;
  logic [2:0] addr_pins;
  logic scl_d_reg, sda_d_reg;
  logic rise, fall, start_cond, stop_cond, addr_match;
  xps_pkg::xps_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] hi_reg, hi_next;
  logic byte_reg, byte_next;
  logic dir_reg, dir_next;
  logic oe_reg, oe_next;
  logic [3:0] rd_reg, rd_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] rb_byte;
  logic apply;
  logic [15:0] word;
  logic [9:0] row_hot;
  logic row_ok;
  logic [79:0] hit;
  logic [79:0] pending_reg, pending_next;
  logic [79:0] live_reg, live_next;
  logic sda_out_reg;

  // ---------------------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // ---------------------------------------------------------------------------
  // Every pin input passes two flip-flops before any logic reads it.
  xps_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({i_scl, i_sda, i_reset_pin_n, i_addr_select_pin_2,
              i_addr_select_pin_1, i_addr_select_pin_0}),
    .o_sync(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign rpin_s = pins_s[3];
  assign addr_pins = pins_s[2:0];

  // Clock edges and start and stop seen at the sampled lines.
  assign rise = scl_s && !scl_d_reg;
  assign fall = !scl_s && scl_d_reg;
  assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign addr_match = shift_reg[7:1] == {xps_pkg::ADDR_FIXED, addr_pins};

  // Readback byte is one row of closed switches, column 0 in bit 0.
  assign rb_byte = live_reg[{rd_reg, 3'b000} +: 8];

  // ---------------------------------------------------------------------------
  // Serial engine
  // ---------------------------------------------------------------------------
  // Only the data line is ever driven, and only by pulling it low.
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    hi_next = hi_reg;
    byte_next = byte_reg;
    dir_next = dir_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    tx_next = tx_reg;
    apply = 1'b0;
    unique case (state_reg)
      xps_pkg::XPS_IDLE, xps_pkg::XPS_IGNORE: begin
      end
      xps_pkg::XPS_ADDR: begin
        if (rise && bit_reg != xps_pkg::BIT_LAST) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
        end else if (fall && bit_reg == xps_pkg::BIT_LAST) begin
          if (addr_match) begin
            oe_next = 1'b1;
            dir_next = shift_reg[0];
            state_next = xps_pkg::XPS_ACK;
          end else begin
            state_next = xps_pkg::XPS_IGNORE;
          end
        end
      end
      xps_pkg::XPS_ACK: begin
        if (fall) begin
          bit_next = 4'h0;
          if (dir_reg) begin
            tx_next = rb_byte;
            oe_next = !rb_byte[7];
            state_next = xps_pkg::XPS_READ;
          end else begin
            oe_next = 1'b0;
            state_next = xps_pkg::XPS_WRITE;
          end
        end
      end
      xps_pkg::XPS_WRITE: begin
        if (rise && bit_reg != xps_pkg::BIT_LAST) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
        end else if (fall && bit_reg == xps_pkg::BIT_LAST) begin
          oe_next = 1'b1;
          state_next = xps_pkg::XPS_ACK;
          if (!byte_reg) begin
            hi_next = shift_reg;
            byte_next = 1'b1;
          end else begin
            apply = 1'b1;
            byte_next = 1'b0;
          end
        end
      end
      xps_pkg::XPS_READ: begin
        if (rise && bit_reg != xps_pkg::BIT_LAST) begin
          bit_next = bit_reg + 4'h1;
        end else if (fall) begin
          if (bit_reg == xps_pkg::BIT_LAST) begin
            oe_next = 1'b0;
            state_next = xps_pkg::XPS_RD_ACK;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = !tx_reg[6];
          end
        end
      end
      xps_pkg::XPS_RD_ACK: begin
        if (rise) begin
          if (sda_s) begin
            state_next = xps_pkg::XPS_IGNORE;
          end else begin
            rd_next = (rd_reg == xps_pkg::ROW_IDX_LAST) ? 4'h0 : rd_reg + 4'h1;
            state_next = xps_pkg::XPS_RD_NEXT;
          end
        end
      end
      xps_pkg::XPS_RD_NEXT: begin
        if (fall) begin
          tx_next = rb_byte;
          oe_next = !rb_byte[7];
          bit_next = 4'h0;
          state_next = xps_pkg::XPS_READ;
        end
      end
    endcase
    // Start and stop win over any byte in progress.
    if (!rpin_s || stop_cond) begin
      state_next = xps_pkg::XPS_IDLE;
      oe_next = 1'b0;
      apply = 1'b0;
    end else if (start_cond) begin
      state_next = xps_pkg::XPS_ADDR;
      bit_next = 4'h0;
      byte_next = 1'b0;
      rd_next = 4'h0;
      oe_next = 1'b0;
      apply = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Switch registers
  // ---------------------------------------------------------------------------
  assign word = {hi_reg, shift_reg};

  xps_row_decode u_row (
    .i_code(word[xps_pkg::WORD_ROW_MSB:xps_pkg::WORD_ROW_LSB]),
    .o_row_hot(row_hot),
    .o_valid(row_ok)
  );

  // One select line per crosspoint, row-major with eight columns per row.
  for (genvar r = 0; r < xps_pkg::ROWS; r++) begin : g_r
    for (genvar c = 0; c < xps_pkg::COLS; c++) begin : g_c
      assign hit[r * xps_pkg::COLS + c] = apply && row_hot[r] &&
        (word[xps_pkg::WORD_COL_MSB:xps_pkg::WORD_COL_LSB] == 3'(c));
    end
  end

  // Latch into the pending layer, copy to the live layer on a load word.
  always_comb begin
    pending_next = (pending_reg & ~hit) | (hit & {80{word[xps_pkg::WORD_DATA_POS]}});
    live_next = live_reg;
    if (apply && row_ok && word[xps_pkg::WORD_LOAD_POS]) begin
      live_next = pending_next;
    end
    if (!rpin_s) begin
      pending_next = xps_pkg::SWITCH_RESET;
      live_next = xps_pkg::SWITCH_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  // Power-up clears all but the line samples, which reset high; all switches open.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= xps_pkg::XPS_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      hi_reg <= 8'h00;
      byte_reg <= 1'b0;
      dir_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_reg <= 4'h0;
      tx_reg <= 8'h00;
      pending_reg <= xps_pkg::SWITCH_RESET;
      live_reg <= xps_pkg::SWITCH_RESET;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      hi_reg <= hi_next;
      byte_reg <= byte_next;
      dir_reg <= dir_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      pending_reg <= pending_next;
      live_reg <= live_next;
      sda_out_reg <= 1'b0;
    end
  end

  // No clock output exists; the data pin only ever pulls low.
  assign o_sda_out = sda_out_reg;
  assign o_sda_oe = oe_reg;
  assign o_switch_closed = live_reg;
  assign o_switch_pending = pending_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_reset_pin_opens: assert property (!rpin_s |=> live_reg == xps_pkg::SWITCH_RESET
      && pending_reg == xps_pkg::SWITCH_RESET)
    else $error("Reset pin did not clear switches.");
  a_live_only_load: assert property (!$stable(live_reg) |->
      ($past(apply) && $past(word[xps_pkg::WORD_LOAD_POS])) || !$past(rpin_s))
    else $error("Switches changed without a load word.");
  a_load_applies: assert property (apply && row_ok && word[xps_pkg::WORD_LOAD_POS] && rpin_s
      |=> live_reg == pending_reg)
    else $error("Load word did not update switches.");
  a_latch_holds: assert property (apply && !word[xps_pkg::WORD_LOAD_POS] && rpin_s
      |=> $stable(live_reg))
    else $error("Latched word changed switches.");
  a_reserved_row: assert property (apply && !row_ok |=> $stable(pending_reg) && $stable(live_reg))
    else $error("Reserved row changed a switch.");
  a_addr_ack: assert property (state_reg == xps_pkg::XPS_ADDR && fall && bit_reg == xps_pkg::BIT_LAST
      && addr_match && rpin_s && !start_cond && !stop_cond |=> oe_reg ##1 oe_reg[*1])
    else $error("Matching address not acknowledged.");
  a_foreign_ignored: assert property (state_reg == xps_pkg::XPS_ADDR && fall
      && bit_reg == xps_pkg::BIT_LAST
      && !addr_match && rpin_s |=> state_reg == xps_pkg::XPS_IGNORE && !oe_reg)
    else $error("Foreign address not ignored.");
  a_start_seen: assert property (start_cond && rpin_s && !stop_cond |=> state_reg == xps_pkg::XPS_ADDR
      && bit_reg == 4'h0 && !oe_reg)
    else $error("Start condition missed.");
  a_stop_seen: assert property (stop_cond |=> state_reg == xps_pkg::XPS_IDLE && !oe_reg)
    else $error("Stop condition missed.");
  a_drive_low_only: assert property ($rose(oe_reg) |-> !$past(scl_s))
    else $error("Data driven while clock high.");
  a_read_entry: assert property (state_reg == xps_pkg::XPS_ACK && dir_reg && fall && rpin_s
      && !start_cond && !stop_cond |=> state_reg == xps_pkg::XPS_READ)
    else $error("Read transfer not started.");

  c_load_word: cover property (apply && row_ok && word[xps_pkg::WORD_LOAD_POS]);
  c_latch_word: cover property (apply && row_ok && !word[xps_pkg::WORD_LOAD_POS]);
  c_read_byte: cover property (state_reg == xps_pkg::XPS_RD_ACK);
  c_foreign: cover property (state_reg == xps_pkg::XPS_IGNORE);

endmodule : xps_switch_ctrl
`default_nettype wire

// *** xps_switch_ctrl_tb.sv ***
// Self-checking testbench for the crosspoint switch control block.
`timescale 1ns/1ps
`default_nettype none
module xps_switch_ctrl_tb;
  logic clk;
  logic resetn;
  logic rst_pin_n;
  logic [2:0] pins;
  logic scl;
  logic m_low;
  logic sda_w;
  logic sda_oe;
  logic sda_out;
  logic [79:0] closed;
  logic [79:0] pending;
  logic [79:0] exp_closed;
  logic [79:0] exp_pend;
  int fail_count;
  int num_checks;

  // Open-drain data wire with a pull-up: low when either party pulls it.
  assign sda_w = !((sda_oe && !sda_out) || m_low);

  xps_switch_ctrl dut (.i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda_w),
    .i_reset_pin_n(rst_pin_n), .i_addr_select_pin_0(pins[0]),
    .i_addr_select_pin_1(pins[1]), .i_addr_select_pin_2(pins[2]),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_switch_closed(closed),
    .o_switch_pending(pending));

  xps_i2c_master m (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low));

  // ---------------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic check(input logic [79:0] seen, input logic [79:0] want);
    num_checks++;
    if (seen !== want) begin
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
      fail_count++;
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Row index of a row select code, or -1 for a reserved code.
  function automatic int row_of(input logic [3:0] code);
    if (code >= 4'h2 && code <= 4'h5) return int'(code) - 2;
    if (code >= 4'h8 && code <= 4'hd) return int'(code) - 4;
    return -1;
  endfunction : row_of

  // One write frame: address byte, two command bytes, stop; then the model.
  task automatic wr_word(input logic [6:0] a, input logic [15:0] w);
    logic ack;
    logic hit;
    int r;
    hit = (a === {xps_pkg::ADDR_FIXED, pins});
    m.start();
    m.wbyte({a, 1'b0}, ack);
    check(ack, !hit);
    m.wbyte(w[15:8], ack);
    check(ack, !hit);
    m.wbyte(w[7:0], ack);
    check(ack, !hit);
    m.stop();
    r = row_of(w[14:11]);
    if (hit && r >= 0) begin
      exp_pend[r * 8 + int'(w[10:8])] = w[15];
      if (w[0]) exp_closed = exp_pend;
    end
    check(closed, exp_closed);
  endtask : wr_word

  // Reads all ten row bytes back and ends with a no-acknowledge.
  task automatic rd_rows();
    logic ack;
    logic [7:0] b;
    m.start();
    m.wbyte({xps_pkg::ADDR_FIXED, pins, 1'b1}, ack);
    check(ack, 1'b0);
    for (int r = 0; r < 10; r++) begin
      m.rbyte(r != 9, b);
      check(b, exp_closed[r * 8 +: 8]);
    end
    m.stop();
    check(sda_oe, 1'b0);
    check(sda_out, 1'b0);
  endtask : rd_rows

  // ---------------------------------------------------------------------------
  // Clock, monitors and tests
  // ---------------------------------------------------------------------------
  // The 100 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The device only moves the data line while the bus clock is low.
  always @(sda_oe) begin
    if (resetn && rst_pin_n) check(scl, 1'b0);
  end

  // Cuts a hang short well beyond the expected run of about 150 us.
  initial begin
    #400000;
    fail_count++;
    final_report();
  end

  // Main sequence of frames with expected switch states.
  initial begin
    resetn = 1'b0;
    rst_pin_n = 1'b1;
    pins = 3'h5;
    fail_count = 0;
    num_checks = 0;
    exp_closed = '0;
    exp_pend = '0;
    repeat (10) @(negedge clk);
    check(closed, 80'h0);
    check(pending, 80'h0);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    for (int c = 0; c < 16; c++) begin
      wr_word({xps_pkg::ADDR_FIXED, pins}, {1'b1, c[3:0], c[2:0], 7'h0, 1'b1});
    end
    wr_word({xps_pkg::ADDR_FIXED, 3'h4}, 16'h9d01);
    wr_word(7'h6d, 16'h9d01);
    wr_word({xps_pkg::ADDR_FIXED, pins}, 16'h9d00);
    wr_word({xps_pkg::ADDR_FIXED, pins}, 16'hc700);
    wr_word({xps_pkg::ADDR_FIXED, pins}, 16'h6d01);
    rd_rows();
    pins = 3'h2;
    repeat (6) @(negedge clk);
    wr_word({xps_pkg::ADDR_FIXED, 3'h5}, 16'ha101);
    wr_word({xps_pkg::ADDR_FIXED, pins}, 16'ha101);
    rst_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    exp_closed = '0;
    exp_pend = '0;
    check(closed, exp_closed);
    check(pending, exp_pend);
    rst_pin_n = 1'b1;
    repeat (6) @(negedge clk);
    wr_word({xps_pkg::ADDR_FIXED, pins}, 16'h9d01);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    exp_closed = '0;
    exp_pend = '0;
    check(closed, exp_closed);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    rd_rows();
    final_report();
  end
endmodule : xps_switch_ctrl_tb
`default_nettype wire

// *** xps_sync.sv ***
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module xps_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [5:0] i_async,
  output logic [5:0] o_sync
);

  logic [5:0] meta_reg;
  logic [5:0] sync_reg;

  // ---------------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= xps_pkg::SYNC_RESET;
      sync_reg <= xps_pkg::SYNC_RESET;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : xps_sync
`default_nettype wire
